// file: asr_regs.svh
/*
  Timing and width constants for the asynchronous static memory host.
  Assumes a 200 MHz ref_clk; all times are as printed for the memory.
*/
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

`define ASR_CLK_PERIOD_PS            5000
`define ASR_ADDR_W                   20
`define ASR_DATA_W                   4
`define ASR_CNT_W                    16
`define ASR_FIRST_ACCESS_WAIT_US     100
`define ASR_READ_CYCLE_TIME_NS       10
`define ASR_ADDRESS_ACCESS_TIME_NS   10
`define ASR_SELECT_ACCESS_TIME_NS    10
`define ASR_OUTPUT_DRIVE_ACCESS_NS   5
`define ASR_WRITE_PULSE_WIDTH_NS     7
`define ASR_WRITE_ADDR_SETUP_NS      7
`define ASR_SELECT_TO_WRITE_END_NS   7
`define ASR_WRITE_DATA_SETUP_NS      5

`endif

// file: asr_pkg.sv
/*
  Types for the asynchronous static memory host.
  Assumes nothing beyond the timing header.
*/
package asr_pkg;

  typedef enum logic [6:0] {
    st_powerup = 7'h01,
    st_idle    = 7'h02,
    st_read    = 7'h04,
    st_write   = 7'h08,
    st_wrec    = 7'h10,
    st_retain  = 7'h20,
    st_recover = 7'h40
  } asr_state_type;

endpackage

// file: asr_host.sv
/*
  Host controller for a 1M x 4 asynchronous static memory: turns single
  word read/write requests into chip select, output drive and write
  strobe sequences, and handles power-up wait and data retention.
  Assumes memory pins are synchronous to ref_clk and the bidirectional
  data wire is resolved outside from data_lines_oe.
*/
// Functional notes
// - write happens while chip select and write strobe are both low
// - read: chip select and output drive low, write strobe high
// - write window is the overlap; either strobe rising ends it
// - write data set-up and hold timed to the ending strobe edge
// - host never drives data lines while the memory drives them
// - address valid no later than chip select falling for reads
// - write strobe write with output drive low needs longer cycle
// - wait 100 us after power-up before the first access
// - deselect before supply drops; wait one read cycle after recovery
// - write address and write strobe low pulse held at least 7 ns
`include "asr_regs.svh"
`timescale 1ns/1ps

module asr_host #(
  parameter int ADDR_W       = `ASR_ADDR_W,
  parameter int DATA_W       = `ASR_DATA_W,
  parameter int CNT_W        = `ASR_CNT_W,
  parameter int POWER_CYCLES = (`ASR_FIRST_ACCESS_WAIT_US * 1000000
                                + `ASR_CLK_PERIOD_PS - 1)
                               / `ASR_CLK_PERIOD_PS
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // user request side
  input  wire logic              req,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              retain_req,
  output logic                   ready,
  output logic      [DATA_W-1:0] rdata,
  output logic                   rvalid,
  output logic                   retained,
  // memory pins
  output logic      [ADDR_W-1:0] address_lines,
  output logic                   select_n,
  output logic                   output_drive_n,
  output logic                   write_strobe_n,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic                   data_lines_oe
);

  // waits rounded up to whole cycles
  localparam int RD_NS = (`ASR_ADDRESS_ACCESS_TIME_NS >
                          `ASR_SELECT_ACCESS_TIME_NS) ?
                         `ASR_ADDRESS_ACCESS_TIME_NS :
                         `ASR_SELECT_ACCESS_TIME_NS;
  localparam int RD_CYC = (RD_NS * 1000 + `ASR_CLK_PERIOD_PS - 1)
                          / `ASR_CLK_PERIOD_PS;
  localparam int DOE_CYC = (`ASR_OUTPUT_DRIVE_ACCESS_NS * 1000
                            + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS;
  localparam int RC_CYC = (`ASR_READ_CYCLE_TIME_NS * 1000
                           + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS;
  localparam int PWE_CYC = (`ASR_WRITE_PULSE_WIDTH_NS * 1000
                            + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS;
  localparam int AW_CYC = (`ASR_WRITE_ADDR_SETUP_NS * 1000
                           + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS;
  localparam int SD_CYC = (`ASR_WRITE_DATA_SETUP_NS * 1000
                           + `ASR_CLK_PERIOD_PS - 1) / `ASR_CLK_PERIOD_PS;
  localparam int RDW_CYC = (RD_CYC > DOE_CYC) ? RD_CYC : DOE_CYC;
  localparam int RDL_CYC = (RDW_CYC > RC_CYC) ? RDW_CYC : RC_CYC;
  localparam int WA_CYC = (PWE_CYC > AW_CYC) ? PWE_CYC : AW_CYC;
  localparam int WR_CYC = (WA_CYC > SD_CYC) ? WA_CYC : SD_CYC;

  asr_pkg::asr_state_type state;
  asr_pkg::asr_state_type next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [ADDR_W-1:0] next_address_lines;
  logic              next_select_n;
  logic              next_output_drive_n;
  logic              next_write_strobe_n;
  logic [DATA_W-1:0] next_data_lines_o;
  logic              next_data_lines_oe;
  logic              next_ready;
  logic [DATA_W-1:0] next_rdata;
  logic              next_rvalid;
  logic              next_retained;

  always_comb begin
    next_state          = state;
    next_cnt            = cnt + CNT_W'(1);
    next_address_lines  = address_lines;
    next_select_n       = select_n;
    next_output_drive_n = output_drive_n;
    next_write_strobe_n = write_strobe_n;
    next_data_lines_o   = data_lines_o;
    next_data_lines_oe  = data_lines_oe;
    next_ready          = 1'h0;
    next_rdata          = rdata;
    next_rvalid         = 1'h0;
    next_retained       = retained;
    unique case (state)
      asr_pkg::st_powerup: begin
        if (cnt == CNT_W'(POWER_CYCLES - 1)) begin
          next_state = asr_pkg::st_idle;
          next_ready = ~retain_req;
        end
      end
      asr_pkg::st_idle: begin
        next_cnt   = '0;
        next_ready = 1'h1;
        // retention wins over a pending request so supply may drop safely
        if (retain_req) begin
          next_state    = asr_pkg::st_retain;
          next_retained = 1'h1;
          next_ready    = 1'h0;
        end else if (req) begin
          next_ready         = 1'h0;
          next_address_lines = req_addr;
          next_select_n      = 1'h0;
          if (req_write) begin
            // output drive stays high so the memory never drives the bus
            next_state          = asr_pkg::st_write;
            next_write_strobe_n = 1'h0;
            next_data_lines_o   = req_wdata;
            next_data_lines_oe  = 1'h1;
          end else begin
            next_state          = asr_pkg::st_read;
            next_output_drive_n = 1'h0;
          end
        end
      end
      asr_pkg::st_read: begin
        if (cnt == CNT_W'(RDL_CYC - 1)) begin
          next_rdata          = data_lines_i;
          next_rvalid         = 1'h1;
          next_select_n       = 1'h1;
          next_output_drive_n = 1'h1;
          next_state          = asr_pkg::st_idle;
          next_ready          = 1'h1;
        end
      end
      asr_pkg::st_write: begin
        if (cnt == CNT_W'(WR_CYC - 1)) begin
          // both strobes rise together; data held one more cycle
          next_select_n       = 1'h1;
          next_write_strobe_n = 1'h1;
          next_state          = asr_pkg::st_wrec;
        end
      end
      asr_pkg::st_wrec: begin
        next_data_lines_oe = 1'h0;
        next_state         = asr_pkg::st_idle;
        next_ready         = 1'h1;
      end
      asr_pkg::st_retain: begin
        next_cnt = '0;
        if (!retain_req) begin
          next_retained = 1'h0;
          next_state    = asr_pkg::st_recover;
        end
      end
      asr_pkg::st_recover: begin
        if (cnt == CNT_W'(RC_CYC - 1)) begin
          next_state = asr_pkg::st_idle;
          next_ready = 1'h1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state          <= asr_pkg::st_powerup;
      cnt            <= '0;
      address_lines  <= '0;
      select_n       <= 1'h1;
      output_drive_n <= 1'h1;
      write_strobe_n <= 1'h1;
      data_lines_o   <= '0;
      data_lines_oe  <= 1'h0;
      ready          <= 1'h0;
      rdata          <= '0;
      rvalid         <= 1'h0;
      retained       <= 1'h0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      address_lines  <= next_address_lines;
      select_n       <= next_select_n;
      output_drive_n <= next_output_drive_n;
      write_strobe_n <= next_write_strobe_n;
      data_lines_o   <= next_data_lines_o;
      data_lines_oe  <= next_data_lines_oe;
      ready          <= next_ready;
      rdata          <= next_rdata;
      rvalid         <= next_rvalid;
      retained       <= next_retained;
    end
  end

  // cycles since reset, saturating; read only by the checks below
  logic [CNT_W-1:0] up_cnt;
  logic [CNT_W-1:0] next_up_cnt;

  always_comb begin
    next_up_cnt = (&up_cnt) ? up_cnt : up_cnt + CNT_W'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      up_cnt <= '0;
    end else begin
      up_cnt <= next_up_cnt;
    end
  end

  property p_no_contention;
    @(posedge ref_clk) disable iff (rst)
      data_lines_oe |-> output_drive_n;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("host drives data while memory output drive is low");

  property p_write_strobes;
    @(posedge ref_clk) disable iff (rst)
      !write_strobe_n |-> !select_n && output_drive_n && data_lines_oe;
  endproperty
  a_write_strobes: assert property (p_write_strobes)
    else $error("write strobe low without select or driven data");

  property p_read_strobes;
    @(posedge ref_clk) disable iff (rst)
      !output_drive_n |-> !select_n && write_strobe_n;
  endproperty
  a_read_strobes: assert property (p_read_strobes)
    else $error("output drive low outside a read");

  property p_write_end;
    @(posedge ref_clk) disable iff (rst)
      $rose(write_strobe_n) |-> $rose(select_n) ##1 !data_lines_oe;
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("write window not closed by both strobes together");

  property p_data_hold;
    @(posedge ref_clk) disable iff (rst)
      $rose(write_strobe_n) |-> data_lines_oe && $stable(data_lines_o);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data changed at end of write window");

  property p_addr_stable;
    @(posedge ref_clk) disable iff (rst)
      !select_n && $past(!select_n) |-> $stable(address_lines);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address changed while selected");

  property p_write_pulse;
    @(posedge ref_clk) disable iff (rst)
      $fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 write_strobe_n;
  endproperty
  a_write_pulse: assert property (p_write_pulse)
    else $error("write strobe pulse not two cycles");

  property p_read_len;
    @(posedge ref_clk) disable iff (rst)
      $fell(output_drive_n) |-> !output_drive_n [*2] ##1 rvalid;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read cycle length or data capture wrong");

  property p_power_wait;
    @(posedge ref_clk) disable iff (rst)
      !select_n |-> up_cnt > CNT_W'(POWER_CYCLES);
  endproperty
  a_power_wait: assert property (p_power_wait)
    else $error("access before power-up wait elapsed");

  property p_retain;
    @(posedge ref_clk) disable iff (rst)
      retained |-> select_n && !ready;
  endproperty
  a_retain: assert property (p_retain)
    else $error("memory selected during retention");

  property p_recover;
    @(posedge ref_clk) disable iff (rst)
      $fell(retained) |-> !ready [*2] ##1 ready;
  endproperty
  a_recover: assert property (p_recover)
    else $error("recovery wait not one read cycle");

endmodule

// file: asr_mem_model.sv
/*
  Behavioural model of the 1M x 4 asynchronous static memory.
  Assumes the bench resolves the shared data wire from both enables.
*/
`timescale 1ns/1ps

module asr_mem_model (
  // memory pins
  input  wire logic [19:0] address_lines,
  input  wire logic        select_n,
  input  wire logic        output_drive_n,
  input  wire logic        write_strobe_n,
  input  wire logic [3:0]  data_in,
  // read side
  output logic      [3:0]  data_out,
  output logic             data_oe
);
  logic [3:0] mem [0:20'hfffff];
  // zero delay: access times are met at once, so host margins
  // are not stressed, only strobe order and duration
  always @* begin
    if (!select_n && !write_strobe_n) begin
      mem[address_lines] = data_in;
    end
  end
  assign data_oe = !select_n && !output_drive_n && write_strobe_n;
  assign data_out = mem[address_lines];
endmodule

// file: asr_host_test.sv
/*
  Self-checking bench for asr_host against a behavioural memory.
  Assumes asr_host and asr_mem_model are compiled first.
*/
`timescale 1ns/1ps

module asr_host_test;
  localparam int PCYC = 8;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  logic        req = 1'h0;
  logic        req_write = 1'h0;
  logic [19:0] req_addr = 20'h0;
  logic [3:0]  req_wdata = 4'h0;
  logic        retain_req = 1'h0;
  logic        ready, rvalid, retained, host_oe, mem_oe;
  logic        select_n, output_drive_n, write_strobe_n;
  logic [19:0] address_lines;
  logic [3:0]  rdata, host_d, mem_d, data_lines;
  logic [3:0]  last_lv = 4'h0;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          k, n;
  // {write, address, data}; read rows carry the expected word
  logic [24:0] rows [10] = '{25'h100000a, 25'h1fffff5, 25'h1123450,
    25'h10abcdf, 25'h000000a, 25'h0fffff5, 25'h0123450, 25'h00abcdf,
    25'h1123459, 25'h0123459};

  always #2.5 ref_clk = ~ref_clk;

  // undriven wire shows a changing pattern, never the last word
  assign data_lines = host_oe ? host_d : (mem_oe ? mem_d : ~last_lv);
  always @(posedge ref_clk) last_lv <= data_lines;

  asr_host #(.POWER_CYCLES(PCYC)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata),
    .retain_req(retain_req), .ready(ready), .rdata(rdata),
    .rvalid(rvalid), .retained(retained),
    .address_lines(address_lines), .select_n(select_n),
    .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n),
    .data_lines_i(data_lines), .data_lines_o(host_d),
    .data_lines_oe(host_oe));

  asr_mem_model i_mem (
    .address_lines(address_lines), .select_n(select_n),
    .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n),
    .data_in(data_lines), .data_out(mem_d), .data_oe(mem_oe));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // request raised early so a busy block must ignore it until ready
  task automatic op(input logic [24:0] r);
    int j, lo;
    @(posedge ref_clk);
    req <= 1'h1;
    {req_write, req_addr, req_wdata} <= r;
    j = 0;
    do begin @(negedge ref_clk); j++; end
    while (ready !== 1'h1 && j < 50);
    @(posedge ref_clk);
    req <= 1'h0;
    j = 0;
    lo = 0;
    do begin
      @(negedge ref_clk);
      j++;
      if (select_n === 1'h0) begin
        lo++;
        chk("pins", {r[24], !r[24], r[24], r[23:4]}, {output_drive_n,
            write_strobe_n, host_oe, address_lines});
      end
    end while ((r[24] ? ready : rvalid) !== 1'h1 && j < 9);
    chk("strobe cycles", 32'h2, lo);
    if (!r[24]) begin
      chk("rdata", r[3:0], rdata);
      @(negedge ref_clk);
      chk("rvalid pulse", 1'h0, rvalid);
    end
  endtask

  always @(negedge ref_clk) begin
    if (host_oe === 1'h1 && mem_oe === 1'h1) begin
      n_mismatch++;
      $display("[FAIL] data wire conflict expected 0 seen 1");
    end
  end

  initial begin
    #20000;
    n_mismatch++;
    $display("[FAIL] watchdog expected done seen timeout");
    stop_test();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset pins", 7'h70, {select_n, output_drive_n, write_strobe_n,
        host_oe, ready, rvalid, retained});
    @(posedge ref_clk);
    rst <= 1'h0;
    k = 0;
    do begin @(negedge ref_clk); k++; end
    while (ready !== 1'h1 && k < 100);
    chk("power-up wait", PCYC + 1, k);
    $display("test reset done");
    foreach (rows[i]) op(rows[i]);
    $display("test table done");
    // retention competes with a write that must be refused
    @(posedge ref_clk);
    retain_req <= 1'h1;
    req <= 1'h1;
    {req_write, req_addr, req_wdata} <= 25'h1123453;
    repeat (6) begin
      @(negedge ref_clk);
      chk("retention select", 1'h1, select_n);
    end
    chk("retained", 2'h2, {retained, ready});
    @(posedge ref_clk);
    req <= 1'h0;
    retain_req <= 1'h0;
    k = 0;
    do begin @(negedge ref_clk); k++; end
    while (retained !== 1'h0 && k < 20);
    chk("retention exit", 32'h2, k);
    n = 0;
    do begin @(negedge ref_clk); n++; end
    while (ready !== 1'h1 && n < 20);
    chk("recovery wait", 32'h2, n);
    op(25'h0123459);
    $display("test retention done");
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("second reset", 7'h70, {select_n, output_drive_n,
        write_strobe_n, host_oe, ready, rvalid, retained});
    // retention asked while still waiting out power-up: ready never rises
    @(posedge ref_clk);
    rst <= 1'h0;
    retain_req <= 1'h1;
    k = 0;
    n = 0;
    do begin
      @(negedge ref_clk);
      k++;
      n += int'(ready === 1'h1);
    end while (retained !== 1'h1 && k < 50);
    chk("retain after power-up", PCYC + 2, k);
    chk("ready during power-up", 32'h0, n);
    @(posedge ref_clk);
    retain_req <= 1'h0;
    op(25'h0fffff5);
    $display("test second reset done");
    stop_test();
  end
endmodule
